// >>> hw/io_alert_pkg.sv
package io_alert_pkg;

    localparam int          PORT_W         = 8;
    localparam int          IDX_W          = 4;
    localparam int          ADDR_LSB       = 2;

    // register indices; byte address is four times the index
    localparam logic [3:0]  IDX_INPUT      = 4'h0;
    localparam logic [3:0]  IDX_OUTPUT     = 4'h1;
    localparam logic [3:0]  IDX_POLARITY   = 4'h2;
    localparam logic [3:0]  IDX_CONFIG     = 4'h3;
    localparam logic [3:0]  IDX_IRQ_STATUS = 4'h4;
    localparam logic [3:0]  IDX_IRQ_MASK   = 4'h5;
    localparam logic [3:0]  IDX_STATE      = 4'h6;

    localparam logic [7:0]  OUTPUT_RST     = 8'hff;
    localparam logic [7:0]  POLARITY_RST   = 8'h00;
    localparam logic [7:0]  CONFIG_RST     = 8'hff;
    localparam logic [7:0]  REF_RST        = 8'hff;

    localparam int          IRQ_W          = 2;
    localparam int          IRQ_CHANGE_BIT = 0;
    localparam int          IRQ_RETURN_BIT = 1;
    localparam logic [1:0]  IRQ_STATUS_RST = 2'h0;
    localparam logic [1:0]  IRQ_MASK_RST   = 2'h0;

    localparam int          STATE_ALERT_BIT = 0;
    localparam int          STATE_LINE_BIT  = 1;
    localparam int          STATE_REF_LSB   = 8;

    localparam int          INIT_CYCLES    = 4;
    localparam logic [2:0]  HSIZE_WORD     = 3'h2;
    localparam logic        HRESP_OKAY     = 1'h0;

    typedef enum logic [0:0] {
        ST_INIT = 1'b0,
        ST_RUN  = 1'b1
    } phase_type;

    typedef struct packed {
        logic [7:0] outp;
        logic [7:0] pol;
        logic [7:0] cfg;
    } port_regs_type;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [3:0] idx;
    } bus_req_type;

    function automatic logic [7:0] changed_bits(input logic [7:0] pins,
                                                input logic [7:0] refv,
                                                input logic [7:0] cfg);
        return (pins ^ refv) & cfg;
    endfunction : changed_bits

endpackage : io_alert_pkg

// >>> hw/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
    parameter int             W       = 9,
    parameter logic [W-1:0]   RST_VAL = '1
) (
    input  wire logic         mclk_i,   // core clock
    input  wire logic         rst_n_i,  // async reset, active low
    input  wire logic [W-1:0] din_i,    // asynchronous pin levels
    output logic      [W-1:0] dout_o    // filtered synchronous levels
);

    initial begin
        if (W < 1) $error("pin_sync: width must be positive");
    end

    logic [W-1:0] s1_q, s1_d;
    logic [W-1:0] s2_q, s2_d;
    logic [W-1:0] s3_q, s3_d;
    logic [W-1:0] stable_q, stable_d;

    // a level is accepted only when the second and third stages agree
    always_comb begin
        s1_d = din_i;
        s2_d = s1_q;
        s3_d = s2_q;
        for (int i = 0; i < W; i++) begin
            stable_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : stable_q[i];
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_q     <= RST_VAL;
            s2_q     <= RST_VAL;
            s3_q     <= RST_VAL;
            stable_q <= RST_VAL;
        end else begin
            s1_q     <= s1_d;
            s2_q     <= s2_d;
            s3_q     <= s3_d;
            stable_q <= stable_d;
        end
    end

    assign dout_o = stable_q;

endmodule : pin_sync

// >>> hw/change_alert.sv
`timescale 1ns/1ps
module change_alert (
    input  wire logic       mclk_i,    // core clock
    input  wire logic       rst_n_i,   // async reset, active low
    input  wire logic       run_i,     // detection enabled after init
    input  wire logic [7:0] pins_i,    // synchronised pin levels
    input  wire logic [7:0] cfg_i,     // direction, 1 = input
    input  wire logic       snap_i,    // input register read accepted
    output logic            alert_o,   // alert level, registered
    output logic [7:0]      ref_o,     // reference snapshot
    output logic            rise_o,    // pulse: alert asserts
    output logic            return_o   // pulse: released by pin return
);

    logic [7:0] ref_q, ref_d;
    logic       alert_q, alert_d;

    always_comb begin
        ref_d   = snap_i ? pins_i : ref_q;
        // output pins are masked, and a pin turned to input is compared at once
        alert_d = run_i & (|io_alert_pkg::changed_bits(pins_i, ref_d, cfg_i));
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ref_q   <= io_alert_pkg::REF_RST;
            alert_q <= 1'b0;
        end else begin
            ref_q   <= ref_d;
            alert_q <= alert_d;
        end
    end

    assign alert_o  = alert_q;
    assign ref_o    = ref_q;
    assign rise_o   = alert_d & ~alert_q;
    assign return_o = alert_q & ~alert_d & ~snap_i;

endmodule : change_alert

// >>> hw/io_expander_alert.sv
// Decided for this implementation: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
module io_expander_alert #(
    parameter int INIT_CYCLES = io_alert_pkg::INIT_CYCLES
) (
    input  wire logic        mclk_i,        // core clock, 250 MHz
    input  wire logic        rst_n_i,       // async power-on reset, active low
    input  wire logic        hsel_i,        // AHB slave select
    input  wire logic [31:0] haddr_i,       // AHB address
    input  wire logic [1:0]  htrans_i,      // AHB transfer type
    input  wire logic        hwrite_i,      // AHB write
    input  wire logic [2:0]  hsize_i,       // AHB size
    input  wire logic [31:0] hwdata_i,      // AHB write data
    input  wire logic        hready_i,      // AHB bus ready
    output logic      [31:0] hrdata_o,      // AHB read data, registered
    output logic             hreadyout_o,   // AHB slave ready
    output logic             hresp_o,       // AHB response, always OKAY
    input  wire logic [7:0]  io_i,          // port pin levels
    output logic      [7:0]  io_o,          // port drive values, registered
    output logic      [7:0]  io_oe_o,       // port drive enables, registered
    input  wire logic        alert_line_i,  // level seen on the alert wire
    output logic             alert_o,       // alert drive value, always low
    output logic             alert_oe_o,    // alert pull-down enable
    output logic             irq_o          // level interrupt, active high
);

    initial begin
        if (INIT_CYCLES < 3) $error("io_expander_alert: INIT_CYCLES below sync depth");
        if (INIT_CYCLES > 255) $error("io_expander_alert: INIT_CYCLES too large");
    end

    // init sequencer
    io_alert_pkg::phase_type phase_q, phase_d;
    logic [7:0]              init_cnt_q, init_cnt_d;
    logic                    run;

    always_comb begin
        phase_d    = phase_q;
        init_cnt_d = init_cnt_q;
        unique case (phase_q)
            io_alert_pkg::ST_INIT: begin
                // lets the pin filters settle before anything is compared
                if (init_cnt_q == 8'(INIT_CYCLES - 1)) begin
                    phase_d = io_alert_pkg::ST_RUN;
                end else begin
                    init_cnt_d = init_cnt_q + 8'h01;
                end
            end
            io_alert_pkg::ST_RUN: begin
                phase_d = io_alert_pkg::ST_RUN;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase_q    <= io_alert_pkg::ST_INIT;
            init_cnt_q <= 8'h00;
        end else begin
            phase_q    <= phase_d;
            init_cnt_q <= init_cnt_d;
        end
    end

    assign run = (phase_q == io_alert_pkg::ST_RUN);

    // pin synchronisers, alert wire shares the same filter
    logic [8:0] sync_out;
    logic [7:0] pins;
    logic       line_low;

    pin_sync #(
        .W       (9),
        .RST_VAL (9'h1ff)
    ) u_sync (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .din_i   ({alert_line_i, io_i}),
        .dout_o  (sync_out)
    );

    assign pins     = sync_out[7:0];
    assign line_low = ~sync_out[8];

    // AHB address phase capture
    io_alert_pkg::bus_req_type req_q, req_d;
    logic                      accept;
    logic                      rd_accept;
    logic [3:0]                acc_idx;
    logic                      addr_hi_zero;

    assign addr_hi_zero = (haddr_i[31:6] == 26'h0) && (haddr_i[1:0] == 2'h0);
    assign acc_idx      = haddr_i[io_alert_pkg::ADDR_LSB +: io_alert_pkg::IDX_W];
    // no access is taken until init is done
    assign accept       = run & hsel_i & htrans_i[1] & hready_i;
    assign rd_accept    = accept & ~hwrite_i;

    always_comb begin
        req_d       = req_q;
        req_d.valid = 1'b0;
        if (accept) begin
            // a misaligned access or a sub-word write is completed but not acted on; a sub-word read of the input register still takes the snapshot
            req_d.valid = addr_hi_zero & (hsize_i == io_alert_pkg::HSIZE_WORD);
            req_d.write = hwrite_i;
            req_d.idx   = acc_idx;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            req_q <= '0;
        end else begin
            req_q <= req_d;
        end
    end

    logic wr_en;
    assign wr_en = req_q.valid & req_q.write;

    // port registers
    io_alert_pkg::port_regs_type regs_q, regs_d;

    always_comb begin
        regs_d = regs_q;
        if (wr_en) begin
            unique case (req_q.idx)
                io_alert_pkg::IDX_OUTPUT:   regs_d.outp = hwdata_i[7:0];
                io_alert_pkg::IDX_POLARITY: regs_d.pol  = hwdata_i[7:0];
                io_alert_pkg::IDX_CONFIG:   regs_d.cfg  = hwdata_i[7:0];
                default:                    regs_d      = regs_q;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            regs_q.outp <= io_alert_pkg::OUTPUT_RST;
            regs_q.pol  <= io_alert_pkg::POLARITY_RST;
            regs_q.cfg  <= io_alert_pkg::CONFIG_RST;
        end else begin
            regs_q <= regs_d;
        end
    end

    // pin drivers
    logic [7:0] io_q, io_d;
    logic [7:0] oe_q, oe_d;

    always_comb begin
        io_d = regs_q.outp;
        oe_d = run ? ~regs_q.cfg : 8'h00;
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            io_q <= io_alert_pkg::OUTPUT_RST;
            oe_q <= 8'h00;
        end else begin
            io_q <= io_d;
            oe_q <= oe_d;
        end
    end

    assign io_o    = io_q;
    assign io_oe_o = oe_q;

    // change detection
    logic       alert;
    logic [7:0] ref_bits;
    logic       ev_rise;
    logic       ev_return;
    logic       snap;

    assign snap = rd_accept & addr_hi_zero & (acc_idx == io_alert_pkg::IDX_INPUT);

    change_alert u_change (
        .mclk_i   (mclk_i),
        .rst_n_i  (rst_n_i),
        .run_i    (run),
        .pins_i   (pins),
        .cfg_i    (regs_q.cfg),
        .snap_i   (snap),
        .alert_o  (alert),
        .ref_o    (ref_bits),
        .rise_o   (ev_rise),
        .return_o (ev_return)
    );

    // open drain: the value is always low, only the enable moves
    assign alert_o    = 1'b0;
    assign alert_oe_o = alert;

    // interrupt status and mask
    logic [1:0] sts_q, sts_d;
    logic [1:0] mask_q, mask_d;
    logic [1:0] sts_set;
    logic [1:0] sts_clr;

    always_comb begin
        sts_set                              = 2'h0;
        sts_set[io_alert_pkg::IRQ_CHANGE_BIT] = ev_rise;
        sts_set[io_alert_pkg::IRQ_RETURN_BIT] = ev_return;
        sts_clr = 2'h0;
        mask_d  = mask_q;
        if (wr_en && req_q.idx == io_alert_pkg::IDX_IRQ_STATUS) begin
            sts_clr = hwdata_i[1:0];
        end
        if (wr_en && req_q.idx == io_alert_pkg::IDX_IRQ_MASK) begin
            mask_d = hwdata_i[1:0];
        end
        // an event in the clearing cycle survives the clear
        sts_d = (sts_q & ~sts_clr) | sts_set;
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sts_q  <= io_alert_pkg::IRQ_STATUS_RST;
            mask_q <= io_alert_pkg::IRQ_MASK_RST;
        end else begin
            sts_q  <= sts_d;
            mask_q <= mask_d;
        end
    end

    assign irq_o = |(sts_q & mask_q);

    // read data, loaded at the address phase so it is stable in the data phase
    logic [31:0] rdata_q, rdata_d;
    logic [31:0] state_word;

    always_comb begin
        state_word = 32'h0;
        state_word[io_alert_pkg::STATE_ALERT_BIT] = alert;
        state_word[io_alert_pkg::STATE_LINE_BIT]  = line_low;
        state_word[io_alert_pkg::STATE_REF_LSB +: 8] = ref_bits;
        rdata_d = 32'h0;
        // a sub-word read answers zero, as a sub-word write is dropped
        if (rd_accept && addr_hi_zero && hsize_i == io_alert_pkg::HSIZE_WORD) begin
            unique case (acc_idx)
                io_alert_pkg::IDX_INPUT:      rdata_d = {24'h0, pins ^ regs_q.pol};
                io_alert_pkg::IDX_OUTPUT:     rdata_d = {24'h0, regs_q.outp};
                io_alert_pkg::IDX_POLARITY:   rdata_d = {24'h0, regs_q.pol};
                io_alert_pkg::IDX_CONFIG:     rdata_d = {24'h0, regs_q.cfg};
                io_alert_pkg::IDX_IRQ_STATUS: rdata_d = {30'h0, sts_q};
                io_alert_pkg::IDX_IRQ_MASK:   rdata_d = {30'h0, mask_q};
                io_alert_pkg::IDX_STATE:      rdata_d = state_word;
                default:                      rdata_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q <= 32'h0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign hrdata_o    = rdata_q;
    // stalls the bus until init completes, then answers with no wait states
    assign hreadyout_o = run;
    assign hresp_o     = io_alert_pkg::HRESP_OKAY;

endmodule : io_expander_alert

// >>> dv/pin_world.sv
`timescale 1ns/1ps
module pin_world (
    input  wire logic [7:0] ext_i,     // levels forced by the outside world
    input  wire logic [7:0] drive_i,   // device drive values
    input  wire logic [7:0] drive_en_i, // device drive enables
    input  wire logic       pull_i,    // alert drive value
    input  wire logic       pull_en_i, // alert pull-down enable
    output logic      [7:0] pins_o,    // resolved pin levels
    output logic            line_o     // resolved alert wire
);
    // a driven pin shows the device value, otherwise the outside level
    assign pins_o = (drive_en_i & drive_i) | (~drive_en_i & ext_i);
    // wire has a pull-up, so released means high
    assign line_o = pull_en_i ? pull_i : 1'b1;
endmodule : pin_world

// >>> dv/io_alert_chk_sva.sv
`timescale 1ns/1ps
module io_alert_chk #(
    parameter int INIT_CYCLES = 4
) (
    input wire logic        mclk_i,      // clock
    input wire logic        rst_n_i,     // reset
    input wire logic        hsel_i,      // select
    input wire logic [31:0] haddr_i,     // address
    input wire logic [1:0]  htrans_i,    // transfer type
    input wire logic        hwrite_i,    // write
    input wire logic [2:0]  hsize_i,     // size
    input wire logic        hready_i,    // bus ready
    input wire logic [31:0] hrdata_o,    // read data
    input wire logic        hreadyout_o, // slave ready
    input wire logic [7:0]  io_i,        // pin levels
    input wire logic [7:0]  io_o,        // drive values
    input wire logic [7:0]  io_oe_o,     // drive enables
    input wire logic        alert_o,     // alert value
    input wire logic        alert_oe_o   // alert enable
);
    logic       taken;
    logic       rd_q;
    logic [3:0] wr_hist_q;
    logic [3:0] ev_cnt_q;
    logic [3:0] ev_cnt_d;
    logic [3:0] init_cnt_q;
    logic [7:0] io_q;
    assign taken = hsel_i & htrans_i[1] & hready_i & hreadyout_o;
    // cycles since the last pin change or bus transfer, saturating
    always_comb begin
        ev_cnt_d = ev_cnt_q + {3'h0, ev_cnt_q != 4'hf};
        if (taken || io_i != io_q) begin
            ev_cnt_d = 4'h0;
        end
    end
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_q <= 1'b0;
            wr_hist_q <= 4'h0;
            ev_cnt_q <= 4'h0;
            init_cnt_q <= 4'h0;
            io_q <= 8'hff;
        end else begin
            rd_q <= taken & ~hwrite_i;
            wr_hist_q <= {wr_hist_q[2:0], taken & hwrite_i};
            ev_cnt_q <= ev_cnt_d;
            init_cnt_q <= init_cnt_q + {3'h0, init_cnt_q != 4'hf};
            io_q <= io_i;
        end
    end
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);
    property p_alert_low;
        alert_o == 1'b0;
    endproperty
    a_alert_low: assert property (p_alert_low) else $error("alert drive not low");
    property p_init;
        hreadyout_o == (init_cnt_q >= INIT_CYCLES);
    endproperty
    a_init: assert property (p_init) else $error("ready out of step with init");
    property p_quiet;
        (init_cnt_q < 4'h2) |-> !alert_oe_o && io_oe_o == 8'h00;
    endproperty
    a_quiet: assert property (p_quiet) else $error("outputs driven out of reset");
    property p_rd_zero;
        !rd_q |-> hrdata_o == 32'h0;
    endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("read data outside read");
    property p_rd_upper;
        rd_q |-> hrdata_o[31:16] == 16'h0;
    endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
    property p_rd_drop;
        taken && !hwrite_i && haddr_i == 32'h0 && hsize_i == io_alert_pkg::HSIZE_WORD
            |=> !alert_oe_o;
    endproperty
    a_rd_drop: assert property (p_rd_drop) else $error("alert kept after input read");
    property p_oe_cause;
        ($changed(io_oe_o) || $changed(io_o)) |-> wr_hist_q != 4'h0;
    endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("drive moved without write");
    property p_alert_cause;
        $changed(alert_oe_o) |-> ev_cnt_q < 4'hc;
    endproperty
    a_alert_cause: assert property (p_alert_cause) else $error("alert moved without cause");
endmodule : io_alert_chk

bind io_expander_alert io_alert_chk #(.INIT_CYCLES(INIT_CYCLES)) io_alert_chk_inst (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hready_i(hready_i),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .io_i(io_i), .io_o(io_o),
    .io_oe_o(io_oe_o), .alert_o(alert_o), .alert_oe_o(alert_oe_o)
);

// >>> dv/io_expander_alert_tb_top.sv
`timescale 1ns/1ps
module io_expander_alert_tb_top;
    logic        mclk;
    logic        rst_n;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hready;
    logic [7:0]  ext;
    logic [7:0]  pins;
    logic [7:0]  drv;
    logic [7:0]  drv_en;
    logic        pull;
    logic        pull_en;
    logic        line;
    logic        irq;
    logic        hresp;
    logic        rd_ph = 1'b0;
    int          mismatches;
    int          total_checks;
    int          seed;
    logic [31:0] pol;
    logic [31:0] expq[$];

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    io_expander_alert #(.INIT_CYCLES(3)) io_expander_alert_inst (
        .mclk_i(mclk), .rst_n_i(rst_n), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
        .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .io_i(pins), .io_o(drv),
        .io_oe_o(drv_en), .alert_line_i(line), .alert_o(pull), .alert_oe_o(pull_en),
        .irq_o(irq)
    );
    pin_world pin_world_inst (
        .ext_i(ext), .drive_i(drv), .drive_en_i(drv_en), .pull_i(pull),
        .pull_en_i(pull_en), .pins_o(pins), .line_o(line)
    );

    task automatic give_verdict;
        if (mismatches == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
    endtask : idle

    // bounded wait for the slave ready at a rising edge
    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge mclk);
        while (hready !== 1'b1) begin
            n++;
            if (n > 60) begin
                mismatches++;
                give_verdict();
            end
            @(posedge mclk);
        end
    endtask : wait_rdy

    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                        input logic [2:0] sz);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        hsize <= sz;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
    endtask : xfer

    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        expq.push_back(e);
        xfer(1'b0, a, 32'h0, io_alert_pkg::HSIZE_WORD);
    endtask : rd

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, io_alert_pkg::HSIZE_WORD);
    endtask : wr

    // read data is taken at the edge that ends the data phase
    always @(posedge mclk) begin
        if (rd_ph && hready) begin
            if (expq.size() == 0) begin
                chk(32'h1, 32'h0);
            end else begin
                chk(hrdata, expq.pop_front());
            end
        end
        rd_ph <= rst_n & hsel & htrans[1] & hready & ~hwrite;
    end

    initial begin
        seed = 63;
        mismatches = 0;
        total_checks = 0;
        rst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = io_alert_pkg::HSIZE_WORD;
        hwdata = 32'h0;
        ext = 8'hff;
        idle(6);
        rst_n <= 1'b1;
        rd(32'h4, 32'hff);
        rd(32'h8, 32'h0);
        rd(32'hc, 32'hff);
        rd(32'h3c, 32'h0);
        expq.push_back(32'h0);
        xfer(1'b0, 32'h4, 32'h0, 3'h0);
        wr(32'h0, 32'h0);
        rd(32'h0, 32'hff);
        pol = {24'h0, 8'($random(seed))};
        wr(32'h8, pol);
        rd(32'h0, 32'hff ^ pol);
        wr(32'h8, 32'h0);
        wr(32'h14, 32'h3);
        ext <= 8'hfb;
        idle(12);
        rd(32'h18, 32'hff03);
        chk(line, 0);
        chk(irq, 1);
        ext <= 8'hff;
        idle(12);
        rd(32'h18, 32'hff00);
        rd(32'h10, 32'h3);
        wr(32'h14, 32'h0);
        idle(1);
        chk(irq, 0);
        wr(32'h14, 32'h3);
        idle(1);
        chk(irq, 1);
        wr(32'h10, 32'h3);
        idle(1);
        chk(irq, 0);
        ext <= 8'hfb;
        idle(12);
        rd(32'h0, 32'hfb);
        idle(12);
        rd(32'h18, 32'hfb00);
        ext <= 8'hff;
        idle(12);
        rd(32'h18, 32'hfb03);
        rd(32'h0, 32'hff);
        wr(32'hc, 32'hfe);
        wr(32'h4, 32'h0);
        idle(12);
        rd(32'h18, 32'hff00);
        chk(drv_en, 32'h1);
        chk(drv, 32'h0);
        rd(32'h0, 32'hfe);
        wr(32'h4, 32'hff);
        wr(32'hc, 32'hff);
        idle(12);
        rd(32'h18, 32'hfe03);
        rd(32'h0, 32'hff);
        repeat (4) begin
            ext <= 8'($random(seed));
            idle(12);
            rd(32'h0, {24'h0, ext});
            idle(12);
            rd(32'h18, {16'h0, ext, 8'h0});
        end
        chk(hresp, 0);
        rst_n <= 1'b0;
        idle(2);
        chk(drv_en, 32'h0);
        chk(pull_en, 0);
        chk(hready, 0);
        rst_n <= 1'b1;
        rd(32'hc, 32'hff);
        idle(4);
        give_verdict();
    end
endmodule : io_expander_alert_tb_top
